// [ascc_ctrl.sv]
`include "ascc_regs.svh"

// *****************************************************************
// Serial channel control of an eight-input converter
// *****************************************************************
// Operation
// - Simultaneous select and clock fall enters track
// - Control word captured on first 8 rises
// - Written channel applies to next conversion
// - First conversion after reset uses input zero
// - Control bits 5..3 are channel, 5 MSB
// - Control bits 7,6,2,1,0 are ignored
// - Channel code selects input of same index
// - Result is 10-bit straight binary
// - Powered from 1st to 16th fall while select low, down when high
// - Continuous mode sleeps between 16th and 1st fall
// - 16 cycles per conversion, repeat while selected
// - Output: 4 zeros, 10 result bits MSB first, 2 zeros
// - Output tristate and clock gated when deselected
// - Track first 3 cycles, convert next 12, off in the last
module ascc_ctrl #(
  parameter int RES_BITS = `ASCC_RESULT_BITS
) (
  // Clock and reset
  input  wire logic                CLK_IN,
  input  wire logic                SRST_IN,
  // Serial pins
  input  wire logic                CS_N_IN,
  input  wire logic                SCLK_IN,
  input  wire logic                DIN_IN,
  output logic                     DOUT_OUT,
  output logic                     DOUT_OE_OUT,
  // Analog side: selected input and digitised sample
  input  wire logic [RES_BITS-1:0] SAMPLE_IN,
  output logic [2:0]               CHAN_SEL_OUT,
  output logic                     TRACK_OUT,
  output logic                     POWER_ON_OUT
);

  // *****************************************************************
  // Pin synchronisers: three stages, change once stages 2 and 3 agree
  // *****************************************************************
  ascc_pkg::ascc_pins_s pins_in;
  ascc_pkg::ascc_pins_s s1_q, s2_q, s3_q;
  ascc_pkg::ascc_pins_s flt_q;

  assign pins_in = '{cs_n: CS_N_IN, sclk: SCLK_IN, din: DIN_IN};

  // Stage chain
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      s1_q <= 3'h6;
      s2_q <= 3'h6;
      s3_q <= 3'h6;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered view: per bit, update only when stages agree
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      flt_q <= 3'h6;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) flt_q[i] <= s2_q[i];
      end
    end
  end

  // *****************************************************************
  // Edge detection on the filtered pins
  // *****************************************************************
  logic cs_n_q, sclk_q;
  wire  cs_fall  = cs_n_q & ~flt_q.cs_n;
  wire  selected = ~flt_q.cs_n;
  // Clock gated off while deselected
  wire  sclk_rise = selected & ~sclk_q & flt_q.sclk;
  wire  sclk_fall = selected & sclk_q & ~flt_q.sclk;
  // Select falling with clock low counts as the first falling edge
  wire  fall_ev   = sclk_fall | (cs_fall & ~flt_q.sclk);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= flt_q.cs_n;
      sclk_q <= flt_q.sclk;
    end
  end

  // *****************************************************************
  // Frame counters
  // *****************************************************************
  logic [3:0] rise_cnt_q;     // Rises within current conversion
  logic [4:0] fall_cnt_q;     // Falls within current conversion, 0..16
  logic       first_conv_q;   // Control word only in first 8 rises of frame
  logic [`ASCC_CTRL_WIDTH-1:0] shift_q;
  ascc_pkg::ascc_chan_t chan_q, next_chan_q;
  ascc_pkg::ascc_phase_e phase_q;
  logic [RES_BITS-1:0] result_q;
  logic dout_q;

  function automatic logic [4:0] fall_next(input logic [4:0] c);
    fall_next = (c == 5'(`ASCC_CONV_CYCLES)) ? 5'h01 : c + 5'h01;
  endfunction

  wire conv_end_rise = sclk_rise & (rise_cnt_q == 4'(`ASCC_CONV_CYCLES - 1));
  // A new frame counts afresh, even after a cut one left a stale count
  wire [4:0] fall_nx = fall_next(cs_fall ? 5'h00 : fall_cnt_q);

  // Rise counter wraps every 16 rises
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || cs_fall) begin
      rise_cnt_q <= 4'h0;
    end else if (sclk_rise) begin
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  // Fall counter: 1st fall of a conversion restarts at one
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || (cs_fall & flt_q.sclk)) begin
      fall_cnt_q <= 5'h00;
    end else if (fall_ev) begin
      fall_cnt_q <= fall_nx;
    end
  end

  // *****************************************************************
  // Control word capture
  // *****************************************************************
  wire word_rise = sclk_rise & first_conv_q & (rise_cnt_q < 4'h8);
  wire word_done = word_rise & (rise_cnt_q == 4'h7);
  wire [`ASCC_CTRL_WIDTH-1:0] word_nx = {shift_q[6:0], flt_q.din};

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shift_q      <= 8'h00;
      first_conv_q <= 1'b1;
      next_chan_q  <= `ASCC_CHAN_RESET;
    end else begin
      if (cs_fall) first_conv_q <= 1'b1;
      else if (conv_end_rise) first_conv_q <= 1'b0;
      if (word_rise) shift_q <= word_nx;
      // Only the address field is kept; other bits have no effect
      if (word_done) next_chan_q <= word_nx[`ASCC_CHAN_MSB:`ASCC_CHAN_LSB];
    end
  end

  // *****************************************************************
  // Track / convert phase and channel in use
  // *****************************************************************
  // Pending channel taken only when a new conversion starts tracking
  wire track_start = fall_ev & (fall_nx == 5'h01);
  wire hold_start  = fall_ev & (fall_nx == 5'(`ASCC_TRACK_CYCLES + 1));
  wire sleep_start = fall_ev & (fall_nx == 5'(`ASCC_CONV_CYCLES));

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      phase_q  <= ascc_pkg::ASCC_OFF;
      chan_q   <= `ASCC_CHAN_RESET;
      result_q <= `ASCC_RESULT_RESET;
    end else begin
      case (phase_q)
        ascc_pkg::ASCC_OFF: begin
          if (track_start) begin
            phase_q <= ascc_pkg::ASCC_TRACK;
            chan_q  <= next_chan_q;
          end
        end
        ascc_pkg::ASCC_TRACK: begin
          if (!selected) phase_q <= ascc_pkg::ASCC_OFF;
          else if (hold_start) begin
            phase_q  <= ascc_pkg::ASCC_CONV;
            result_q <= SAMPLE_IN;
          end
        end
        ascc_pkg::ASCC_CONV: begin
          // Sleep from the 16th fall until the next 1st fall
          if (!selected || sleep_start) phase_q <= ascc_pkg::ASCC_OFF;
        end
        default: phase_q <= ascc_pkg::ASCC_OFF;
      endcase
    end
  end

  // *****************************************************************
  // Serial output, updated on falling edges
  // *****************************************************************
  // Falls 5..14 carry the result MSB first; others are zero
  wire in_data = (fall_nx > 5'(`ASCC_LEAD_ZEROS)) &&
                 (fall_nx <= 5'(`ASCC_LEAD_ZEROS + RES_BITS));
  wire [4:0] bit_idx = 5'(`ASCC_LEAD_ZEROS + RES_BITS) - fall_nx;
  // The result is latched at the 4th fall, so fall 5 already sees it
  wire dout_nx = in_data ? result_q[bit_idx[3:0]] : 1'b0;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || !selected) begin
      dout_q <= 1'b0;
    end else if (fall_ev) begin
      dout_q <= dout_nx;
    end
  end

  // *****************************************************************
  // Outputs
  // *****************************************************************
  assign DOUT_OUT     = dout_q;
  assign DOUT_OE_OUT  = selected;
  assign CHAN_SEL_OUT = chan_q;
  assign TRACK_OUT    = (phase_q == ascc_pkg::ASCC_TRACK);
  // Powered while selected and tracking or converting; off from the 16th fall to the next 1st fall
  assign POWER_ON_OUT = selected && (phase_q != ascc_pkg::ASCC_OFF);

endmodule

// [ascc_regs.svh]
`ifndef ASCC_REGS_SVH
`define ASCC_REGS_SVH
// Control word layout
`define ASCC_CTRL_WIDTH     8
`define ASCC_CHAN_MSB       5
`define ASCC_CHAN_LSB       3
`define ASCC_CHAN_RESET     3'h0
// Frame timing, in serial clock cycles
`define ASCC_CONV_CYCLES    16
`define ASCC_TRACK_CYCLES   3
`define ASCC_LEAD_ZEROS     4
`define ASCC_RESULT_BITS    10
`define ASCC_RESULT_RESET   10'h000
`endif

// [ascc_pkg.sv]
package ascc_pkg;
  // Converter phase inside one 16-cycle conversion
  typedef enum logic [2:0] {
    ASCC_OFF   = 3'b001,
    ASCC_TRACK = 3'b010,
    ASCC_CONV  = 3'b100
  } ascc_phase_e;

  // Serial pins seen from the device
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } ascc_pins_s;

  typedef logic [2:0] ascc_chan_t;
endpackage

// [ascc_ctrl_checker.sv]
// ****************************************
// Pin and phase relations of the converter
// ****************************************
module ascc_ctrl_checker (
  // Clock and reset
  input wire logic       CLK_IN,
  input wire logic       SRST_IN,
  // Pins and status
  input wire logic       CS_N_IN,
  input wire logic       SCLK_IN,
  input wire logic       DOUT_OUT,
  input wire logic       DOUT_OE_OUT,
  input wire logic [2:0] CHAN_SEL_OUT,
  input wire logic       TRACK_OUT,
  input wire logic       POWER_ON_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // Track must outlast a few system clocks
  sequence s_hold; TRACK_OUT[*8]; endsequence
  sequence s_start; $fell(CS_N_IN) && !SCLK_IN; endsequence
  a_oe_on_select: assert property ($fell(CS_N_IN) |-> ##[2:8] DOUT_OE_OUT)
    else $error("output not enabled after select");
  a_oe_off_deselect: assert property ($rose(CS_N_IN) |-> ##[2:8] !DOUT_OE_OUT)
    else $error("output still enabled after deselect");
  a_dout_quiet_off: assert property (!DOUT_OE_OUT |-> !DOUT_OUT)
    else $error("data out not low while deselected");
  // Power only once a low select has passed the pin filter
  a_power_needs_select: assert property (POWER_ON_OUT |-> !$past(CS_N_IN, 4))
    else $error("powered while deselected");
  a_track_on_start: assert property (s_start |-> ##[2:10] TRACK_OUT && POWER_ON_OUT)
    else $error("no track after select with clock low");
  a_track_three_cycles: assert property ($rose(TRACK_OUT) |-> s_hold ##[30:50] $fell(TRACK_OUT))
    else $error("track phase length wrong");
  a_track_zero_out: assert property (TRACK_OUT |-> !DOUT_OUT)
    else $error("data out high during leading zeros");
  a_chan_at_track: assert property ($changed(CHAN_SEL_OUT) |-> TRACK_OUT)
    else $error("channel changed outside track");
  a_wake_with_track: assert property ($rose(POWER_ON_OUT) |-> ##[0:2] TRACK_OUT)
    else $error("woke up without starting track");
endmodule
bind ascc_ctrl ascc_ctrl_checker chk_i (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CS_N_IN(CS_N_IN),
  .SCLK_IN(SCLK_IN), .DOUT_OUT(DOUT_OUT), .DOUT_OE_OUT(DOUT_OE_OUT),
  .CHAN_SEL_OUT(CHAN_SEL_OUT), .TRACK_OUT(TRACK_OUT), .POWER_ON_OUT(POWER_ON_OUT));

// [ascc_host.sv]
// ****************************************
// Host serial controller model
// ****************************************
module ascc_host (
  // Clock and pins
  input  wire logic clk_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      din_out,
  input  wire logic dout_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] q[$];
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Clock toggled while deselected must be ignored
  task automatic toggle(input int n);
    repeat (n) begin
      sclk_out <= 1'b1;
      tick(8);
      sclk_out <= 1'b0;
      tick(8);
    end
  endtask
  // Select falls with clock low, so it counts as fall 1
  task automatic frame(input int n, input logic [7:0] w);
    logic [15:0] r;
    cs_n_out <= 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 16; i++) begin
        din_out <= (k == 0 && i < 8) ? w[7-i] : ~w[i%8];
        tick(8);
        sclk_out <= 1'b1;
        r[15-i] = dout_in;
        tick(8);
        if (i < 15 || k < n - 1) sclk_out <= 1'b0;
      end
      q.push_back(r);
    end
    // Deselect with clock high; data line then wanders
    cs_n_out <= 1'b1;
    tick(8);
    sclk_out <= 1'b0;
    din_out <= ~din_out;
    tick(8);
  endtask
endmodule

// [test_adc_serial_channel_control.sv]
// ****************************************
// Self-checking bench
// ****************************************
module test_adc_serial_channel_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, srst = 1'b1;
  logic [9:0] sample = 10'h000;
  logic cs_n, sclk, din, dout, oe, trk, pwr;
  logic [2:0] chan;
  logic [9:0] vals[8];
  int seed = 48042, err_count = 0, cmp_count = 0, cur = 0;
  always #12.5 clk = ~clk;
  // Analog side: sample of the selected input
  always @(posedge clk) sample <= vals[chan];
  // Released line reads as the inverse of the last value
  wire dout_pin = oe ? dout : ~dout;
  ascc_host host (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
    .dout_in(dout_pin));
  ascc_ctrl uut (.CLK_IN(clk), .SRST_IN(srst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .DIN_IN(din),
    .DOUT_OUT(dout), .DOUT_OE_OUT(oe), .SAMPLE_IN(sample), .CHAN_SEL_OUT(chan),
    .TRACK_OUT(trk), .POWER_ON_OUT(pwr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Model: control word of first conversion picks the next channel
  task automatic run(input int n, input logic [7:0] w);
    for (int k = 0; k < n; k++) begin
      if (k == 0) host.frame(n, w);
      chk(host.q.pop_front(), {4'h0, vals[cur], 2'b00});
      if (k == n - 1) chk({13'h0, chan}, 16'(cur));
      if (k == 0) cur = w[5:3];
    end
  endtask
  task automatic summarize;
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    // Distinct upper bits tell the channels apart
    for (int i = 0; i < 8; i++) vals[i] = {i[2:0], 7'($random(seed))};
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    host.tick(8);
    run(1, 8'hc5);
    $display("test power-up channel done");
    for (int i = 0; i < 8; i++) run(1, {2'($random(seed)), i[2:0], 3'($random(seed))});
    $display("test channel sweep done");
    run(3, 8'h10);
    $display("test continuous done");
    host.tick(400);
    chk({13'h0, trk, pwr, oe}, 16'h0000);
    host.toggle(5);
    run(1, 8'h00);
    $display("test burst and gating done");
    summarize;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(20000 * 25);
    err_count++;
    summarize;
  end
endmodule
